// >>> shared/status_regs.svh
// status report register bank: offsets, field positions, reset values
// assumes a 32-bit AHB-Lite slave decoding the low address byte
`ifndef STATUS_REGS_SVH
`define STATUS_REGS_SVH

// ------------------------------------------------------------------
// register offsets (byte addresses)
// ------------------------------------------------------------------
`define OFF_CMD    8'h00
`define OFF_RESP   8'h04
`define OFF_ALL_STATUS_QUERY   8'h08
`define OFF_STAT   8'h24
`define OFF_ISTAT  8'h28
`define OFF_IMASK  8'h2C
`define OFF_ENA0   8'h30
`define OFF_ENA1   8'h34

// ------------------------------------------------------------------
// sizes and field positions
// ------------------------------------------------------------------
`define ALL_STATUS_QUERY_WORDS   7
`define EVT_REGS     6
`define EV_ESR       0
`define EV_INR       1
`define EV_DDR       2
`define EV_CMR       3
`define EV_EXR       4
`define EV_URR       5
`define CMD_OP_MSB   20
`define CMD_OP_LSB   16
`define STB_INS_BIT  0
`define STB_ESB_BIT  5
`define STB_MAV_BIT  6
`define ESR_OPC_BIT  0
`define IRQ_RESP_BIT 0
`define IRQ_SRQ_BIT  1
`define IRQ_WAI_BIT  2
`define IRQ_BITS     3
`define HSIZE_WORD   3'h2

// ------------------------------------------------------------------
// reset values
// ------------------------------------------------------------------
`define REG_RST   16'h0000
`define IRQ_RST   3'h0

`endif

// >>> shared/status_pkg.sv
// status report register bank: shared types
// assumes nothing beyond a SystemVerilog compiler
package status_pkg;
  typedef logic [15:0] word_t;

  // command codes written to the command register
  typedef enum logic [4:0] {
    CMD_NOP  = 5'h00,
    CMD_CLS  = 5'h01,
    CMD_ESE  = 5'h02,
    CMD_OPC  = 5'h03,
    CMD_PRE  = 5'h04,
    CMD_SRE  = 5'h05,
    CMD_INE  = 5'h06,
    CMD_WAI  = 5'h07,
    Q_ALL_STATUS_QUERY   = 5'h08,
    Q_CMR    = 5'h09,
    Q_DDR    = 5'h0A,
    Q_ESR    = 5'h0B,
    Q_EXR    = 5'h0C,
    Q_INR    = 5'h0D,
    Q_IST    = 5'h0E,
    Q_STB    = 5'h0F,
    Q_URR    = 5'h10
  } cmd_t;
endpackage

// >>> logic/status_report_registers.sv
// status report register bank behind an AHB-Lite slave port
// assumes event inputs, mav and op_pending come from logic on hclk
`timescale 1ns/1ps
`default_nettype none
`include "status_regs.svh"

module status_report_registers (
  input  wire logic          hclk,       // bus clock
  input  wire logic          hresetn,    // async reset, active low
  input  wire logic          hsel,       // slave select
  input  wire logic [31:0]   haddr,      // byte address
  input  wire logic [1:0]    htrans,     // transfer type
  input  wire logic          hwrite,     // write when high
  input  wire logic [2:0]    hsize,      // transfer size
  input  wire logic          hready,     // bus ready
  input  wire logic [31:0]   hwdata,     // write data
  output logic [31:0]        hrdata,     // read data
  output logic               hreadyout,  // slave ready
  output logic               hresp,      // always okay
  input  wire status_pkg::word_t esr_set, // event status set pulses
  input  wire status_pkg::word_t inr_set, // internal change set pulses
  input  wire status_pkg::word_t ddr_set, // device error set pulses
  input  wire status_pkg::word_t cmr_set, // command error set pulses
  input  wire status_pkg::word_t exr_set, // execution error set pulses
  input  wire status_pkg::word_t urr_set, // user request set pulses
  input  wire logic          mav,        // message available level
  input  wire logic          op_pending, // operations still running
  output logic               srq,        // service request level
  output logic               ist,        // individual status level
  output logic               busy,       // holding off commands
  output logic               irq         // interrupt, active high
);
  import status_pkg::*;

  // ------------------------------------------------------------------
  // bus data phase
  // ------------------------------------------------------------------
  logic        dp_q;
  logic        dp_wr_q;
  logic        dp_word_q;
  logic [7:0]  dp_addr_q;
  logic        wai_q;
  logic        stall;
  logic        wdone;
  logic        exec;
  cmd_t        op;
  word_t       val;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_q      <= 1'b0;
      dp_wr_q   <= 1'b0;
      dp_word_q <= 1'b0;
      dp_addr_q <= 8'h00;
    end else if (hready) begin
      dp_q      <= hsel & htrans[1];
      dp_wr_q   <= hwrite;
      dp_word_q <= (hsize == `HSIZE_WORD);
      dp_addr_q <= haddr[7:0];
    end
  end

  // a command write is stretched while a wait is in force
  assign stall     = dp_q & dp_wr_q & (dp_addr_q == `OFF_CMD) & wai_q;
  assign hreadyout = ~stall;
  assign hresp     = 1'b0;
  assign wdone     = dp_q & dp_wr_q & dp_word_q & ~stall;
  assign exec      = wdone & (dp_addr_q == `OFF_CMD);
  assign op        = cmd_t'(hwdata[`CMD_OP_MSB:`CMD_OP_LSB]);
  assign val       = hwdata[15:0];

  // ------------------------------------------------------------------
  // event and error registers
  // ------------------------------------------------------------------
  word_t       evt_q [`EVT_REGS];
  word_t       set_v [`EVT_REGS];
  logic [5:0]  clr_v;
  logic        is_query;

  always_comb begin
    set_v[`EV_ESR] = esr_set;
    set_v[`EV_INR] = inr_set;
    set_v[`EV_DDR] = ddr_set;
    set_v[`EV_CMR] = cmr_set;
    set_v[`EV_EXR] = exr_set;
    set_v[`EV_URR] = urr_set;
    if (exec && op == CMD_OPC) begin
      set_v[`EV_ESR][`ESR_OPC_BIT] = 1'b1;
    end
    clr_v    = 6'h00;
    is_query = 1'b0;
    if (exec) begin
      unique case (op)
        CMD_CLS: clr_v = 6'h3F;
        Q_ALL_STATUS_QUERY: begin
          clr_v    = 6'h3F;
          is_query = 1'b1;
        end
        Q_CMR: begin
          clr_v[`EV_CMR] = 1'b1;
          is_query       = 1'b1;
        end
        Q_DDR: begin
          clr_v[`EV_DDR] = 1'b1;
          is_query       = 1'b1;
        end
        Q_ESR: begin
          clr_v[`EV_ESR] = 1'b1;
          is_query       = 1'b1;
        end
        Q_EXR: begin
          clr_v[`EV_EXR] = 1'b1;
          is_query       = 1'b1;
        end
        Q_INR: begin
          clr_v[`EV_INR] = 1'b1;
          is_query       = 1'b1;
        end
        Q_URR: begin
          clr_v[`EV_URR] = 1'b1;
          is_query       = 1'b1;
        end
        Q_IST, Q_STB: is_query = 1'b1;
        default: ;
      endcase
    end
  end

  // a set arriving with its clear survives
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < `EVT_REGS; i++) begin
        evt_q[i] <= `REG_RST;
      end
    end else begin
      for (int i = 0; i < `EVT_REGS; i++) begin
        evt_q[i] <= (evt_q[i] & ~{16{clr_v[i]}}) | set_v[i];
      end
    end
  end

  // ------------------------------------------------------------------
  // enable registers
  // ------------------------------------------------------------------
  word_t ese_q;
  word_t sre_q;
  word_t pre_q;
  word_t ine_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ese_q <= `REG_RST;
      sre_q <= `REG_RST;
      pre_q <= `REG_RST;
      ine_q <= `REG_RST;
    end else if (exec) begin
      unique case (op)
        CMD_ESE: ese_q <= val;
        CMD_SRE: sre_q <= val;
        CMD_PRE: pre_q <= val;
        CMD_INE: ine_q <= val;
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // status byte and summaries
  // ------------------------------------------------------------------
  word_t stb;

  always_comb begin
    stb               = `REG_RST;
    stb[`STB_INS_BIT] = |(evt_q[`EV_INR] & ine_q);
    stb[`STB_ESB_BIT] = |(evt_q[`EV_ESR] & ese_q);
    stb[`STB_MAV_BIT] = mav;
  end

  assign srq = |(stb & sre_q);
  assign ist = |(stb & pre_q);

  // ------------------------------------------------------------------
  // query responses
  // ------------------------------------------------------------------
  word_t resp_q;
  word_t resp_d;
  word_t all_status_query_q [`ALL_STATUS_QUERY_WORDS];

  always_comb begin
    unique case (op)
      Q_CMR:   resp_d = evt_q[`EV_CMR];
      Q_DDR:   resp_d = evt_q[`EV_DDR];
      Q_ESR:   resp_d = evt_q[`EV_ESR];
      Q_EXR:   resp_d = evt_q[`EV_EXR];
      Q_INR:   resp_d = evt_q[`EV_INR];
      Q_URR:   resp_d = evt_q[`EV_URR];
      Q_IST:   resp_d = {15'h0000, ist};
      default: resp_d = stb;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      resp_q <= `REG_RST;
    end else if (is_query && op != Q_ALL_STATUS_QUERY) begin
      resp_q <= resp_d;
    end
  end

  // snapshot order: stb, esr, inr, ddr, cmr, exr, urr
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < `ALL_STATUS_QUERY_WORDS; i++) begin
        all_status_query_q[i] <= `REG_RST;
      end
    end else if (exec && op == Q_ALL_STATUS_QUERY) begin
      all_status_query_q[0] <= stb;
      for (int i = 0; i < `EVT_REGS; i++) begin
        all_status_query_q[i + 1] <= evt_q[i];
      end
    end
  end

  // ------------------------------------------------------------------
  // wait for pending operations
  // ------------------------------------------------------------------
  logic wai_done;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wai_q <= 1'b0;
    end else if (exec && op == CMD_WAI && op_pending) begin
      wai_q <= 1'b1;
    end else if (!op_pending) begin
      wai_q <= 1'b0;
    end
  end

  assign busy     = wai_q;
  assign wai_done = wai_q & ~op_pending;

  // ------------------------------------------------------------------
  // interrupts
  // ------------------------------------------------------------------
  logic [`IRQ_BITS-1:0] istat_q;
  logic [`IRQ_BITS-1:0] imask_q;
  logic [`IRQ_BITS-1:0] ievt;
  logic [`IRQ_BITS-1:0] iclr;
  logic                 srq_q;

  always_comb begin
    ievt                = `IRQ_RST;
    ievt[`IRQ_RESP_BIT] = is_query;
    ievt[`IRQ_SRQ_BIT]  = srq & ~srq_q;
    ievt[`IRQ_WAI_BIT]  = wai_done;
    iclr = (wdone && dp_addr_q == `OFF_ISTAT) ? hwdata[`IRQ_BITS-1:0] : `IRQ_RST;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      srq_q   <= 1'b0;
      istat_q <= `IRQ_RST;
    end else begin
      srq_q   <= srq;
      istat_q <= (istat_q & ~iclr) | ievt;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      imask_q <= `IRQ_RST;
    end else if (wdone && dp_addr_q == `OFF_IMASK) begin
      imask_q <= hwdata[`IRQ_BITS-1:0];
    end
  end

  assign irq = |(istat_q & imask_q);

  // ------------------------------------------------------------------
  // read data
  // ------------------------------------------------------------------
  always_comb begin
    hrdata = 32'h0000_0000;
    if (dp_q && !dp_wr_q) begin
      unique case (dp_addr_q)
        `OFF_RESP:  hrdata = {16'h0000, resp_q};
        `OFF_STAT:  hrdata = {29'h0000_0000, ist, srq, wai_q};
        `OFF_ISTAT: hrdata = {29'h0000_0000, istat_q};
        `OFF_IMASK: hrdata = {29'h0000_0000, imask_q};
        `OFF_ENA0:  hrdata = {sre_q, ese_q};
        `OFF_ENA1:  hrdata = {ine_q, pre_q};
        default: begin
          for (int i = 0; i < `ALL_STATUS_QUERY_WORDS; i++) begin
            if (dp_addr_q == `OFF_ALL_STATUS_QUERY + 8'(4 * i)) begin
              hrdata = {16'h0000, all_status_query_q[i]};
            end
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_cmd(cmd_t c);
    exec && op == c;
  endsequence

  a_all_status_query_clears_all: assert property (s_cmd(Q_ALL_STATUS_QUERY) |=>
    evt_q[`EV_CMR] == $past(cmr_set) && evt_q[`EV_URR] == $past(urr_set))
    else $error("all-status query left a register uncleared");
  a_all_status_query_word_order: assert property (s_cmd(Q_ALL_STATUS_QUERY) |=>
    all_status_query_q[4] == $past(evt_q[`EV_CMR]) && all_status_query_q[0] == $past(stb))
    else $error("all-status snapshot out of order");
  a_cls_zeroes_regs: assert property (s_cmd(CMD_CLS) |=>
    evt_q[`EV_ESR] == $past(esr_set) && evt_q[`EV_EXR] == $past(exr_set))
    else $error("clear-status left bits set");
  a_cmr_read_clear: assert property (s_cmd(Q_CMR) |=>
    resp_q == $past(evt_q[`EV_CMR]) && evt_q[`EV_CMR] == $past(cmr_set))
    else $error("command error query wrong");
  a_ddr_read_clear: assert property (s_cmd(Q_DDR) |=>
    resp_q == $past(evt_q[`EV_DDR]) && evt_q[`EV_DDR] == $past(ddr_set))
    else $error("device error query wrong");
  a_ese_load_value: assert property (s_cmd(CMD_ESE) |=> ese_q == $past(val))
    else $error("event enable not loaded");
  a_esr_read_clear: assert property (s_cmd(Q_ESR) |=>
    resp_q == $past(evt_q[`EV_ESR]) && evt_q[`EV_ESR] == $past(esr_set))
    else $error("event status query wrong");
  a_opc_sets_bit: assert property (s_cmd(CMD_OPC) |=> evt_q[`EV_ESR][`ESR_OPC_BIT])
    else $error("operation complete bit lost");
  a_exr_read_clear: assert property (s_cmd(Q_EXR) |=>
    resp_q == $past(evt_q[`EV_EXR]) && evt_q[`EV_EXR] == $past(exr_set))
    else $error("execution error query wrong");
  a_ine_load_value: assert property (s_cmd(CMD_INE) |=> ine_q == $past(val))
    else $error("internal change enable not loaded");
  a_inr_read_clear: assert property (s_cmd(Q_INR) |=>
    resp_q == $past(evt_q[`EV_INR]) && evt_q[`EV_INR] == $past(inr_set))
    else $error("internal change query wrong");
  a_pre_load_value: assert property (s_cmd(CMD_PRE) |=> pre_q == $past(val))
    else $error("parallel poll enable not loaded");
  a_sre_load_value: assert property (s_cmd(CMD_SRE) |=> sre_q == $past(val))
    else $error("service request enable not loaded");
  a_urr_read_clear: assert property (s_cmd(Q_URR) |=>
    resp_q == $past(evt_q[`EV_URR]) && evt_q[`EV_URR] == $past(urr_set))
    else $error("user request query wrong");
  a_ist_no_change: assert property (s_cmd(Q_IST) |=>
    resp_q == {15'h0000, $past(ist)} && ($past(evt_q[`EV_ESR]) & ~evt_q[`EV_ESR]) == 16'h0000)
    else $error("individual status query altered state");
  a_wai_holds_cmds: assert property (wai_q && op_pending |-> !exec)
    else $error("command taken during wait");
  a_wai_releases: assert property (wai_q ##1 !op_pending [*2] |-> !wai_q)
    else $error("wait not released");
  a_stb_keeps_bits: assert property (s_cmd(Q_STB) |=>
    resp_q == $past(stb) && ($past(evt_q[`EV_INR]) & ~evt_q[`EV_INR]) == 16'h0000)
    else $error("status byte query wrong");

endmodule // status_report_registers
`default_nettype wire

// >>> test/ctl_model.sv
// controller model: single word AHB-Lite transfers to the status bank
// assumes one slave whose hreadyout is fed back as hready
`timescale 1ns/1ps
`default_nettype none
module ctl_model (
  input  wire logic        hclk,    // bus clock
  input  wire logic        hready,  // bus ready
  input  wire logic [31:0] hrdata,  // read data
  output var  logic        hsel,    // slave select
  output var  logic [31:0] haddr,   // byte address
  output var  logic [1:0]  htrans,  // transfer type
  output var  logic        hwrite,  // write when high
  output var  logic [2:0]  hsize,   // transfer size
  output var  logic [31:0] hwdata   // write data
);
  initial begin
    hsel   = 1'b0;
    haddr  = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0000_0000;
  end

  // call just after a rising edge; released lines show inverted values
  task automatic xfer(input logic wr, input logic [7:0] adr, input logic [31:0] wd,
                      output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, adr};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize  <= 3'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    haddr  <= ~haddr;
    hwdata <= wr ? wd : ~hwdata;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    hwdata <= ~hwdata;
  endtask
endmodule // ctl_model
`default_nettype wire

// >>> test/status_report_registers_tb_top.sv
// self-checking bench for the status report register bank
// assumes the controller model drives the bus side
`timescale 1ns/1ps
`default_nettype none
`include "status_regs.svh"
module status_report_registers_tb_top;
  import status_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic        mav, op_pending, srq, ist, busy, irq;
  logic [31:0] haddr, hwdata, hrdata, rdat;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  word_t       set_v [`EVT_REGS];
  cmd_t        qop   [`EVT_REGS] = '{Q_ESR, Q_INR, Q_DDR, Q_CMR, Q_EXR, Q_URR};
  int          n_mismatch = 0;
  int          samples_checked = 0;

  assign hready = hreadyout;

  status_report_registers status_report_registers_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .esr_set(set_v[`EV_ESR]), .inr_set(set_v[`EV_INR]),
    .ddr_set(set_v[`EV_DDR]), .cmr_set(set_v[`EV_CMR]), .exr_set(set_v[`EV_EXR]),
    .urr_set(set_v[`EV_URR]), .mav(mav), .op_pending(op_pending), .srq(srq), .ist(ist),
    .busy(busy), .irq(irq));

  ctl_model ctl_model_i (
    .hclk(hclk), .hready(hready), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  // ------------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------------
  task automatic close_out;
    $display("compares %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %08h expected %08h", $time, seen, exp);
    end
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    ctl_model_i.xfer(1'b1, a, d, rdat);
  endtask

  task automatic cmd(input cmd_t op, input word_t v);
    bus_wr(`OFF_CMD, {11'h000, op, v});
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    ctl_model_i.xfer(1'b0, a, 32'h0000_0000, rdat);
    check(rdat, e);
  endtask

  // caller delays so the level passed in has settled; then back onto an edge
  task automatic bit_chk(input logic b, input logic e);
    check({31'h0, b}, {31'h0, e});
    @(posedge hclk);
  endtask

  task automatic pulse(input int i, input word_t p);
    set_v[i] <= p;
    @(posedge hclk);
    set_v[i] <= 16'h0000;
    @(posedge hclk);
  endtask

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_reset;
    rd_chk(`OFF_ENA0, 32'h0000_0000);
    check({31'h0, hresp}, 32'h0000_0000);
    rd_chk(`OFF_ENA1, 32'h0000_0000);
    rd_chk(`OFF_STAT, 32'h0000_0000);
    rd_chk(`OFF_ISTAT, 32'h0000_0000);
    rd_chk(8'h40, 32'h0000_0000);
  endtask

  task automatic t_enable;
    cmd(CMD_ESE, 16'h00FF);
    cmd(CMD_SRE, 16'h0020);
    cmd(CMD_PRE, 16'h0001);
    cmd(CMD_INE, 16'h0003);
    rd_chk(`OFF_ENA0, 32'h0020_00FF);
    rd_chk(`OFF_ENA1, 32'h0003_0001);
  endtask

  task automatic t_events;
    for (int i = 0; i < `EVT_REGS; i++) begin
      pulse(i, 16'h8001 ^ 16'(i << 4));
      cmd(qop[i], 16'h0000);
      rd_chk(`OFF_RESP, 32'(16'h8001 ^ 16'(i << 4)));
      cmd(qop[i], 16'h0000);
      rd_chk(`OFF_RESP, 32'h0000_0000);
    end
  endtask

  task automatic t_status;
    mav <= 1'b1;
    cmd(CMD_OPC, 16'h0000);
    cmd(Q_STB, 16'h0000);
    rd_chk(`OFF_RESP, 32'h0000_0060);
    cmd(Q_STB, 16'h0000);
    rd_chk(`OFF_RESP, 32'h0000_0060);
    rd_chk(`OFF_STAT, 32'h0000_0002);
    #1 bit_chk(srq, 1'b1);
    pulse(`EV_INR, 16'h0001);
    cmd(Q_IST, 16'h0000);
    rd_chk(`OFF_RESP, 32'h0000_0001);
    #1 bit_chk(ist, 1'b1);
    cmd(Q_INR, 16'h0000);
    rd_chk(`OFF_RESP, 32'h0000_0001);
    rd_chk(`OFF_ISTAT, 32'h0000_0003);
    bus_wr(`OFF_IMASK, 32'h0000_0002);
    #1 bit_chk(irq, 1'b1);
    bus_wr(`OFF_ISTAT, 32'h0000_0002);
    #1 bit_chk(irq, 1'b0);
    rd_chk(`OFF_ISTAT, 32'h0000_0001);
  endtask

  task automatic t_all_status_query;
    cmd(CMD_CLS, 16'h0000);
    for (int i = 0; i < `EVT_REGS; i++) pulse(i, 16'h0101 << i);
    cmd(Q_ALL_STATUS_QUERY, 16'h0000);
    rd_chk(`OFF_ALL_STATUS_QUERY, 32'h0000_0061);
    for (int k = 0; k < `EVT_REGS; k++)
      rd_chk(8'(`OFF_ALL_STATUS_QUERY + 4 * (k + 1)), 32'(16'h0101 << k));
    cmd(Q_STB, 16'h0000);
    rd_chk(`OFF_RESP, 32'h0000_0040);
    cmd(Q_DDR, 16'h0000);
    rd_chk(`OFF_RESP, 32'h0000_0000);
  endtask

  task automatic t_cls;
    for (int i = 0; i < `EVT_REGS; i++) pulse(i, 16'hFFFF);
    cmd(CMD_CLS, 16'h0000);
    cmd(Q_ALL_STATUS_QUERY, 16'h0000);
    for (int k = 0; k < `EVT_REGS; k++)
      rd_chk(8'(`OFF_ALL_STATUS_QUERY + 4 * (k + 1)), 32'h0000_0000);
  endtask

  task automatic t_wait;
    op_pending <= 1'b1;
    cmd(CMD_WAI, 16'h0000);
    #1 bit_chk(busy, 1'b1);
    fork
      cmd(CMD_ESE, 16'h0011);
      begin
        repeat (4) @(posedge hclk);
        #1;
        check({31'h0, hreadyout}, 32'h0000_0000);
        @(posedge hclk);
        op_pending <= 1'b0;
      end
    join
    rd_chk(`OFF_ENA0, 32'h0020_0011);
    ctl_model_i.xfer(1'b0, `OFF_ISTAT, 32'h0000_0000, rdat);
    check(rdat & 32'h0000_0004, 32'h0000_0004);
  endtask

  // ------------------------------------------------------------------
  // clock, reset, sequence, watchdog
  // ------------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  initial begin
    hresetn    = 1'b0;
    mav        = 1'b0;
    op_pending = 1'b0;
    for (int i = 0; i < `EVT_REGS; i++) set_v[i] = 16'h0000;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset;
    t_enable;
    t_events;
    t_status;
    t_all_status_query;
    t_cls;
    t_wait;
    close_out;
  end

  initial begin
    repeat (20000) @(posedge hclk);
    n_mismatch++;
    close_out;
  end
endmodule // status_report_registers_tb_top
`default_nettype wire
